// File: shared/ptev_regs.svh
// register offsets, field positions and reset values of the pin task
// and event unit; assumes byte addresses on a 12-bit register port
`ifndef PTEV_REGS_SVH
`define PTEV_REGS_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define PTEV_NUM_CH 8
`define PTEV_NUM_PIN 32
`define PTEV_ADDR_W 12

// ---------------------------------------------------------------
// register offsets, stride 4 per channel
// ---------------------------------------------------------------
`define PTEV_TASK_OUT_OFS 12'h000
`define PTEV_TASK_SET_OFS 12'h030
`define PTEV_TASK_LOW_OFS 12'h060
`define PTEV_EV_IN_OFS 12'h100
`define PTEV_EV_PORT_OFS 12'h17C
`define PTEV_IRQ_SET_OFS 12'h304
`define PTEV_IRQ_CLR_OFS 12'h308
`define PTEV_CONFIG_OFS 12'h510
`define PTEV_STRIDE 12'h004

// ---------------------------------------------------------------
// config word fields
// ---------------------------------------------------------------
`define PTEV_CFG_MODE_LSB 0
`define PTEV_CFG_PSEL_LSB 8
`define PTEV_CFG_POL_LSB 16
`define PTEV_CFG_INIT_BIT 20
`define PTEV_CFG_RESET 32'h00000000

// ---------------------------------------------------------------
// interrupt enable layout
// ---------------------------------------------------------------
`define PTEV_IRQ_PORT_BIT 31
`define PTEV_IRQ_MASK 32'h800000FF
`define PTEV_IRQ_RESET 32'h00000000

`endif

// File: shared/ptev_pkg.sv
// types shared by the pin task and event unit
// assumes the register header is compiled alongside
package ptev_pkg;

    // channel mode
    typedef enum logic [1:0] {
        ptev_mode_off = 2'b00,
        ptev_mode_event = 2'b01,
        ptev_mode_task = 2'b11
    } ptev_mode_type;

    // task action and event condition share one field
    typedef enum logic [1:0] {
        ptev_pol_none = 2'b00,
        ptev_pol_high = 2'b01,
        ptev_pol_low = 2'b10,
        ptev_pol_toggle = 2'b11
    } ptev_pol_type;

endpackage

// File: logic/ptev_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs and the core clock
`timescale 1ns/1ps
`default_nettype none

module ptev_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_next;

    // accept a change only once stages two and three agree
    always_comb begin
        out_next = sync_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s3_reg[i];
            end
        end
    end

    // stage registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            sync_out <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sync_out <= out_next;
        end
    end

endmodule

`default_nettype wire

// File: logic/ptev_top.sv
// pin task and event unit: eight channels tied to pads, port event
// assumes the gpio module supplies out/dir defaults and the watch level
// Notes on behaviour
// RULE1 - eight independent channels, each bound to one selected pin
// RULE2 - per channel: set task, drive-low task, configurable task
// RULE3 - set task drives pin high, drive-low task drives it low
// RULE4 - configurable task sets, clears or inverts per action field
// RULE5 - channel event on rising, falling or any change of its pin
// RULE6 - controlled pin ignores gpio output value and gpio writes
// RULE7 - disabled channel returns pin to gpio value and configuration
// RULE8 - same-cycle priority: configurable, then drive-low, then set
// RULE9 - no-action configurable task still wins, pin stays unchanged
// RULE10 - entering task mode drives pin to initial level
// RULE11 - combined event on each rising edge of watch signal
// RULE12 - software clears watch sources before idle sleep
// RULE13 - latched source still high after clear gives fresh rising edge
// RULE14 - off request while watch high gives wakeup reset
// RULE15 - combined event wakes sleeping processor
// RULE16 - software masks, configures, clears flag, then unmasks
// RULE17 - event mode forces input, task mode forces output
// RULE18 - software changes pin select only while disabled
// RULE19 - event flags sticky until written zero; enabled flag interrupts
`timescale 1ns/1ps
`default_nettype none
`include "ptev_regs.svh"

module ptev_top #(
    parameter int NCH = `PTEV_NUM_CH,
    parameter int NPIN = `PTEV_NUM_PIN
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [`PTEV_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interconnect tasks and events
    input wire logic [NCH-1:0] task_out_trig,
    input wire logic [NCH-1:0] task_set_trig,
    input wire logic [NCH-1:0] drive_low_task_trig,
    output logic [NCH-1:0] event_in_pulse,
    output logic event_port_pulse,
    // gpio module defaults and watch sources
    input wire logic [NPIN-1:0] gpio_out_val,
    input wire logic [NPIN-1:0] gpio_dir_val,
    input wire logic gpio_latched_mode,
    input wire logic gpio_latch_any,
    input wire logic gpio_latch_clear,
    // pads
    input wire logic [NPIN-1:0] pad_in,
    input wire logic pad_detect,
    output logic [NPIN-1:0] pad_out,
    output logic [NPIN-1:0] pad_oe,
    // system
    input wire logic sys_off_req,
    output logic wake_reset,
    output logic wake_req,
    output logic irq
);
    import ptev_pkg::*;

    localparam int PW = $clog2(NPIN);

    // one clock and reset for every check in this module
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // pad input synchronisers
    // ---------------------------------------------------------------
    logic [NPIN-1:0] pin_s;
    logic det_s;

    ptev_sync #(.WIDTH(NPIN + 1)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({pad_detect, pad_in}),
        .sync_out({det_s, pin_s})
    );

    // ---------------------------------------------------------------
    // channel state
    // ---------------------------------------------------------------
    ptev_mode_type mode_reg [NCH];
    logic [PW-1:0] psel_reg [NCH];
    ptev_pol_type pol_reg [NCH];
    logic init_reg [NCH];
    logic level_reg [NCH];
    logic [NCH-1:0] ev_in_reg;
    logic [NCH-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            logic do_out;
            logic do_set;
            logic do_low;
            logic cfg_wr;
            logic ev_clr;
            logic sel_pin;
            logic prev_reg;
            ptev_mode_type mode_next;
            logic [PW-1:0] psel_next;
            ptev_pol_type pol_next;
            logic init_next;
            logic level_next;
            logic ev_next;

            // task triggers from the port and from register writes
            assign do_out = task_out_trig[g] | (reg_wr & reg_wdata[0] &
                (reg_addr == `PTEV_TASK_OUT_OFS + `PTEV_STRIDE * 12'(g)));
            assign do_set = task_set_trig[g] | (reg_wr & reg_wdata[0] &
                (reg_addr == `PTEV_TASK_SET_OFS + `PTEV_STRIDE * 12'(g)));
            assign do_low = drive_low_task_trig[g] | (reg_wr & reg_wdata[0] &
                (reg_addr == `PTEV_TASK_LOW_OFS + `PTEV_STRIDE * 12'(g)));
            assign cfg_wr = reg_wr &
                (reg_addr == `PTEV_CONFIG_OFS + `PTEV_STRIDE * 12'(g));
            assign ev_clr = reg_wr & ~reg_wdata[0] &
                (reg_addr == `PTEV_EV_IN_OFS + `PTEV_STRIDE * 12'(g));
            assign sel_pin = pin_s[psel_reg[g]]; // [RULE1]

            // edge detection in event mode
            always_comb begin
                hit[g] = 1'b0;
                if (mode_reg[g] == ptev_mode_event) begin
                    case (pol_reg[g])
                        ptev_pol_high: hit[g] = sel_pin & ~prev_reg; // [RULE5]
                        ptev_pol_low: hit[g] = ~sel_pin & prev_reg; // [RULE5]
                        ptev_pol_toggle: hit[g] = sel_pin ^ prev_reg; // [RULE5]
                        default: hit[g] = 1'b0;
                    endcase
                end
            end

            // next config, level and flag
            always_comb begin
                mode_next = mode_reg[g];
                psel_next = psel_reg[g];
                pol_next = pol_reg[g];
                init_next = init_reg[g];
                level_next = level_reg[g];
                if (cfg_wr) begin
                    mode_next = ptev_mode_type'(reg_wdata[`PTEV_CFG_MODE_LSB +: 2]);
                    psel_next = reg_wdata[`PTEV_CFG_PSEL_LSB +: PW];
                    pol_next = ptev_pol_type'(reg_wdata[`PTEV_CFG_POL_LSB +: 2]);
                    init_next = reg_wdata[`PTEV_CFG_INIT_BIT];
                end
                // configurable task first, then drive-low, then set
                if (mode_reg[g] == ptev_mode_task) begin
                    if (do_out) begin // [RULE8]
                        case (pol_reg[g])
                            ptev_pol_high: level_next = 1'b1; // [RULE4]
                            ptev_pol_low: level_next = 1'b0; // [RULE4]
                            ptev_pol_toggle: level_next = ~level_reg[g]; // [RULE4]
                            default: level_next = level_reg[g]; // [RULE9]
                        endcase
                    end else if (do_low) begin
                        level_next = 1'b0; // [RULE3] [RULE2]
                    end else if (do_set) begin
                        level_next = 1'b1; // [RULE3] [RULE2]
                    end
                end
                // entering task mode loads the initial level
                if (mode_next == ptev_mode_task && mode_reg[g] != ptev_mode_task) begin
                    level_next = init_next; // [RULE10]
                end
                ev_next = hit[g] | (ev_in_reg[g] & ~ev_clr); // [RULE19]
            end

            // channel registers
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mode_reg[g] <= ptev_mode_off;
                    psel_reg[g] <= '0;
                    pol_reg[g] <= ptev_pol_none;
                    init_reg[g] <= 1'b0;
                    level_reg[g] <= 1'b0;
                    ev_in_reg[g] <= 1'b0;
                    prev_reg <= 1'b0;
                    event_in_pulse[g] <= 1'b0;
                end else begin
                    mode_reg[g] <= mode_next;
                    psel_reg[g] <= psel_next;
                    pol_reg[g] <= pol_next;
                    init_reg[g] <= init_next;
                    level_reg[g] <= level_next;
                    ev_in_reg[g] <= ev_next;
                    prev_reg <= sel_pin;
                    event_in_pulse[g] <= hit[g];
                end
            end

            // task and event checks
            AST_LOW_BEATS_SET: assert property (mode_reg[g] == ptev_mode_task // [RULE8]
                && !do_out && do_low && !cfg_wr |=> !level_reg[g])
                else $error("drive-low did not win over set");
            AST_OUT_NONE_HOLD: assert property (mode_reg[g] == ptev_mode_task // [RULE9]
                && pol_reg[g] == ptev_pol_none && do_out && !cfg_wr
                |=> $stable(level_reg[g]))
                else $error("no-action task changed the pin");
            AST_TOGGLE: assert property (mode_reg[g] == ptev_mode_task // [RULE4]
                && pol_reg[g] == ptev_pol_toggle && do_out && !cfg_wr
                |=> level_reg[g] != $past(level_reg[g]))
                else $error("toggle task did not invert");
            AST_INIT_LEVEL: assert property (cfg_wr && mode_reg[g] != ptev_mode_task // [RULE10]
                && reg_wdata[1:0] == 2'b11 |=> level_reg[g] == init_reg[g])
                else $error("task mode entry missed initial level");
            AST_FLAG_STICKY: assert property (ev_in_reg[g] && !ev_clr // [RULE19]
                |=> ev_in_reg[g])
                else $error("event flag dropped without clear");
            AST_EDGE_EVENT: assert property (hit[g] |=> ev_in_reg[g] // [RULE5]
                && event_in_pulse[g])
                else $error("pin edge lost");
            COV_TOGGLE: cover property (mode_reg[g] == ptev_mode_task && do_out
                && pol_reg[g] == ptev_pol_toggle);
            COV_EDGE: cover property (hit[g]);
        end
    endgenerate

    // ---------------------------------------------------------------
    // pad ownership
    // ---------------------------------------------------------------
    logic [NPIN-1:0] pad_out_next;
    logic [NPIN-1:0] pad_oe_next;

    // gpio values unless a channel owns the pin
    always_comb begin
        pad_out_next = gpio_out_val; // [RULE7]
        pad_oe_next = gpio_dir_val; // [RULE7]
        for (int p = 0; p < NPIN; p++) begin
            for (int c = 0; c < NCH; c++) begin
                if (psel_reg[c] == PW'(p)) begin
                    if (mode_reg[c] == ptev_mode_task) begin
                        pad_out_next[p] = level_reg[c]; // [RULE6]
                        pad_oe_next[p] = 1'b1; // [RULE17]
                    end else if (mode_reg[c] == ptev_mode_event) begin
                        pad_oe_next[p] = 1'b0; // [RULE17]
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // combined watch, port event, wakeup
    // ---------------------------------------------------------------
    logic gap_reg;
    logic watch;
    logic watch_prev_reg;
    logic port_rise;
    logic ev_port_reg;
    logic ev_port_next;
    logic port_clr;

    // a latch clear forces one low cycle so a held latch re-rises
    assign watch = gpio_latched_mode ? (gpio_latch_any & ~gap_reg) : det_s; // [RULE13]
    assign port_rise = watch & ~watch_prev_reg; // [RULE11]
    assign port_clr = reg_wr & ~reg_wdata[0] & (reg_addr == `PTEV_EV_PORT_OFS);
    assign ev_port_next = port_rise | (ev_port_reg & ~port_clr); // [RULE19]

    // ---------------------------------------------------------------
    // interrupt enable and read port
    // ---------------------------------------------------------------
    logic [31:0] inten_reg;
    logic [31:0] inten_next;
    logic [31:0] rdata_next;
    logic [31:0] flags;

    assign flags = {ev_port_reg, {(31 - NCH){1'b0}}, ev_in_reg};

    // enable set and clear writes
    always_comb begin
        inten_next = inten_reg;
        if (reg_wr && reg_addr == `PTEV_IRQ_SET_OFS) begin
            inten_next = inten_reg | (reg_wdata & `PTEV_IRQ_MASK);
        end else if (reg_wr && reg_addr == `PTEV_IRQ_CLR_OFS) begin
            inten_next = inten_reg & ~reg_wdata;
        end
    end

    // read decode, unmapped reads zero
    always_comb begin
        rdata_next = 32'h00000000;
        if (reg_addr == `PTEV_EV_PORT_OFS) begin
            rdata_next = {31'h00000000, ev_port_reg};
        end else if (reg_addr == `PTEV_IRQ_SET_OFS || reg_addr == `PTEV_IRQ_CLR_OFS) begin
            rdata_next = inten_reg;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (reg_addr == `PTEV_EV_IN_OFS + `PTEV_STRIDE * 12'(c)) begin
                    rdata_next = {31'h00000000, ev_in_reg[c]};
                end
                if (reg_addr == `PTEV_CONFIG_OFS + `PTEV_STRIDE * 12'(c)) begin
                    rdata_next[`PTEV_CFG_MODE_LSB +: 2] = mode_reg[c];
                    rdata_next[`PTEV_CFG_PSEL_LSB +: PW] = psel_reg[c];
                    rdata_next[`PTEV_CFG_POL_LSB +: 2] = pol_reg[c];
                    rdata_next[`PTEV_CFG_INIT_BIT] = init_reg[c];
                end
            end
        end
        if (!reg_rd) begin
            rdata_next = 32'h00000000;
        end
    end

    // shared registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out <= '0;
            pad_oe <= '0;
            gap_reg <= 1'b0;
            watch_prev_reg <= 1'b0;
            ev_port_reg <= 1'b0;
            event_port_pulse <= 1'b0;
            wake_req <= 1'b0;
            wake_reset <= 1'b0;
            inten_reg <= `PTEV_IRQ_RESET;
            reg_rdata <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            pad_out <= pad_out_next;
            pad_oe <= pad_oe_next;
            gap_reg <= gpio_latch_clear;
            watch_prev_reg <= watch;
            ev_port_reg <= ev_port_next;
            event_port_pulse <= port_rise;
            wake_req <= port_rise; // [RULE15]
            wake_reset <= sys_off_req & watch; // [RULE14]
            inten_reg <= inten_next;
            reg_rdata <= rdata_next;
            irq <= |(flags & inten_reg); // [RULE19]
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_PORT_EVENT: assert property (port_rise |=> ev_port_reg && wake_req // [RULE11]
        && event_port_pulse)
        else $error("watch rise gave no port event");
    AST_OFF_WAKE: assert property (sys_off_req && watch |=> wake_reset) // [RULE14]
        else $error("off request while watch high gave no reset");
    AST_LATCH_REEDGE: assert property (gpio_latched_mode && gpio_latch_clear // [RULE13]
        && gpio_latch_any ##1 gpio_latched_mode && gpio_latch_any
        ##1 gpio_latched_mode && gpio_latch_any |-> port_rise)
        else $error("held latch gave no fresh edge");
    AST_TASK_OWNS_PAD: assert property (mode_reg[0] == ptev_mode_task // [RULE6]
        && $stable(mode_reg[0]) && $stable(psel_reg[0]) && $stable(level_reg[0])
        |=> pad_oe[$past(psel_reg[0])] && pad_out[$past(psel_reg[0])] == $past(level_reg[0]))
        else $error("task pin not driven by channel");
    AST_IRQ_LEVEL: assert property (ev_port_reg && inten_reg[`PTEV_IRQ_PORT_BIT] // [RULE19]
        |=> irq)
        else $error("enabled port flag gave no interrupt");
    COV_PORT: cover property (port_rise && inten_reg[`PTEV_IRQ_PORT_BIT]);
    COV_WAKE: cover property (wake_reset);

endmodule

`default_nettype wire

// File: dv/ptev_pad_model.sv
// pad model: the pins outside the pin task and event unit
// assumes pad_oe high while the unit or the gpio module drives a pin
`timescale 1ns/1ps
`default_nettype none

module ptev_pad_model (
    // pad side of the unit
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    // levels of the outside world
    input wire logic [31:0] ext_level,
    output logic [31:0] pad_in
);
    // driven pads read back their own level, input pads the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the pin task and event unit
// assumes the unit, its package, header and the pad model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ptev_regs.svh"

module testbench;
    import ptev_pkg::*;
    // ----------------------------------------------------------------
    // signals and pulse counters
    // ----------------------------------------------------------------
    logic core_clk, rst_n, reg_wr, reg_rd, pad_detect, sys_off_req, wake_reset, wake_req, irq;
    logic event_port_pulse, gpio_latched_mode, gpio_latch_any, gpio_latch_clear;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_data, gpio_out_val, gpio_dir_val;
    logic [31:0] pad_in, pad_out, pad_oe, ext_level;
    logic [7:0] task_out_trig, task_set_trig, drive_low_task_trig, event_in_pulse;
    logic [2:0] ops [6] = '{3'b010, 3'b001, 3'b100, 3'b111, 3'b011, 3'b110};
    logic [5:0] lvl = 6'b101010;
    int errors = 0, checks = 0, in_cnt = 0, port_cnt = 0, wake_cnt = 0, off_cnt = 0;

    ptev_top ptev_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .task_out_trig(task_out_trig), .task_set_trig(task_set_trig),
        .drive_low_task_trig(drive_low_task_trig), .event_in_pulse(event_in_pulse),
        .event_port_pulse(event_port_pulse), .gpio_out_val(gpio_out_val),
        .gpio_dir_val(gpio_dir_val), .gpio_latched_mode(gpio_latched_mode),
        .gpio_latch_any(gpio_latch_any), .gpio_latch_clear(gpio_latch_clear),
        .pad_in(pad_in), .pad_detect(pad_detect), .pad_out(pad_out), .pad_oe(pad_oe),
        .sys_off_req(sys_off_req), .wake_reset(wake_reset), .wake_req(wake_req), .irq(irq));

    ptev_pad_model ptev_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .pad_in(pad_in));

    // count one-cycle pulses of the unit
    always @(posedge core_clk) begin
        in_cnt <= in_cnt + $countones(event_in_pulse);
        port_cnt <= port_cnt + int'(event_port_pulse);
        wake_cnt <= wake_cnt + int'(wake_req);
        off_cnt <= off_cnt + int'(wake_reset);
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_data = reg_rdata;
    endtask

    // trigger tasks of channel 0: ops = {configurable, drive-low, set}
    task automatic fire(input logic [2:0] o);
        @(posedge core_clk);
        task_out_trig <= {7'h00, o[2]};
        drive_low_task_trig <= {7'h00, o[1]};
        task_set_trig <= {7'h00, o[0]};
        @(posedge core_clk);
        task_out_trig <= 8'h00;
        drive_low_task_trig <= 8'h00;
        task_set_trig <= 8'h00;
    endtask

    function automatic logic [31:0] cfg(input ptev_mode_type m, input logic [4:0] ps,
        input ptev_pol_type p, input logic init);
        cfg = 32'h00000000;
        cfg[`PTEV_CFG_MODE_LSB +: 2] = m;
        cfg[`PTEV_CFG_PSEL_LSB +: 5] = ps;
        cfg[`PTEV_CFG_POL_LSB +: 2] = p;
        cfg[`PTEV_CFG_INIT_BIT] = init;
    endfunction

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // cut a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        give_verdict();
    end

    initial begin
        ptev_pol_type p;
        {rst_n, reg_wr, reg_rd, pad_detect, sys_off_req} = 5'h00;
        {gpio_latched_mode, gpio_latch_any, gpio_latch_clear} = 3'h0;
        {reg_addr, reg_wdata, ext_level} = '0;
        {task_out_trig, task_set_trig, drive_low_task_trig} = '0;
        gpio_out_val = 32'h5A5A00C3;
        gpio_dir_val = 32'h800000D0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(2);
        // after reset the pads follow the gpio module
        chk(pad_out, gpio_out_val);
        chk(pad_oe, gpio_dir_val);
        rd(`PTEV_IRQ_SET_OFS);
        chk(rd_data, `PTEV_IRQ_RESET);
        rd(`PTEV_CONFIG_OFS);
        chk(rd_data, `PTEV_CFG_RESET);
        rd(12'h400);
        chk(rd_data, 32'h00000000);
        // task mode, toggle action, same-cycle task mixes
        wr(`PTEV_CONFIG_OFS, cfg(ptev_mode_task, 5'd5, ptev_pol_toggle, 1'b1));
        settle(2);
        chk(pad_out[5], 1'b1);
        chk(pad_oe[5], 1'b1);
        for (int i = 0; i < 6; i++) begin
            fire(ops[i]);
            settle(2);
            chk(pad_out[5], lvl[i]);
        end
        wr(`PTEV_TASK_LOW_OFS, 32'h00000001);
        settle(2);
        chk(pad_out[5], 1'b0);
        // set, clear and no-action after a release; tasks ignored while released
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? ptev_pol_high : (k == 1) ? ptev_pol_low : ptev_pol_none;
            wr(`PTEV_CONFIG_OFS, cfg(ptev_mode_off, 5'd5, p, 1'b1));
            fire(3'b011);
            settle(2);
            chk(pad_out[5], gpio_out_val[5]);
            chk(pad_oe[5], gpio_dir_val[5]);
            wr(`PTEV_CONFIG_OFS, cfg(ptev_mode_task, 5'd5, p, p != ptev_pol_high));
            settle(2);
            chk(pad_out[5], p != ptev_pol_high);
            fire((p == ptev_pol_none) ? 3'b111 : 3'b100);
            settle(2);
            chk(pad_out[5], p != ptev_pol_low);
        end
        // interrupt enables, then edge events of channel 7 on pin 31
        wr(`PTEV_IRQ_SET_OFS, 32'hFFFFFFFF);
        rd(`PTEV_IRQ_SET_OFS);
        chk(rd_data, `PTEV_IRQ_MASK);
        wr(`PTEV_IRQ_CLR_OFS, 32'h0000007F);
        rd(`PTEV_IRQ_CLR_OFS);
        chk(rd_data, 32'h80000080);
        for (int k = 1; k < 4; k++) begin
            p = ptev_pol_type'(2'(k));
            wr(`PTEV_CONFIG_OFS + 12'h01C, cfg(ptev_mode_event, 5'd31, p, 1'b0));
            settle(8);
            chk(pad_oe[31], 1'b0);
            in_cnt = 0;
            @(posedge core_clk);
            ext_level[31] <= 1'b1;
            settle(10);
            chk(in_cnt, (p != ptev_pol_low) ? 1 : 0);
            @(posedge core_clk);
            ext_level[31] <= 1'b0;
            settle(10);
            chk(in_cnt, (p == ptev_pol_toggle) ? 2 : 1);
            rd(`PTEV_EV_IN_OFS + 12'h01C);
            chk(rd_data, 32'h00000001);
            chk(irq, 1'b1);
            wr(`PTEV_EV_IN_OFS + 12'h01C, 32'h00000000);
            settle(2);
            chk(irq, 1'b0);
        end
        // combined event: software masks, clears, unmasks
        wr(`PTEV_IRQ_CLR_OFS, 32'h80000080);
        wr(`PTEV_EV_PORT_OFS, 32'h00000000);
        wr(`PTEV_IRQ_SET_OFS, 32'h80000000);
        {port_cnt, wake_cnt} = '0;
        @(posedge core_clk);
        pad_detect <= 1'b1;
        settle(10);
        chk(port_cnt, 1);
        chk(wake_cnt, 1);
        chk(irq, 1'b1);
        @(posedge core_clk);
        sys_off_req <= 1'b1;
        @(posedge core_clk);
        sys_off_req <= 1'b0;
        settle(2);
        chk(off_cnt, 1);
        wr(`PTEV_IRQ_CLR_OFS, 32'h80000000);
        settle(2);
        chk(irq, 1'b0);
        @(posedge core_clk);
        pad_detect <= 1'b0;
        wr(`PTEV_EV_PORT_OFS, 32'h00000000);
        rd(`PTEV_EV_PORT_OFS);
        chk(rd_data, 32'h00000000);
        // latched source still high after a clear gives a fresh edge
        @(posedge core_clk);
        gpio_latched_mode <= 1'b1;
        gpio_latch_any <= 1'b1;
        settle(10);
        port_cnt = 0;
        @(posedge core_clk);
        gpio_latch_clear <= 1'b1;
        @(posedge core_clk);
        gpio_latch_clear <= 1'b0;
        settle(10);
        chk(port_cnt, 1);
        give_verdict();
    end
endmodule

`default_nettype wire
